/* ext_bus_pkg.sv */
// package: offsets, fields, reset values, encodings and carriers of the bus block
package ext_bus_pkg;
   // avalon register offsets (byte addresses, one word each)
   localparam logic [3:0] memory_bus_control_addr = 4'h0; // control word
   localparam logic [3:0] port_g_register_addr = 4'h4; // pull-up controls
   localparam logic [3:0] bus_status_addr = 4'h8; // pin function status
   // memory_bus_control field positions
   localparam int ext_bus_disable_bit = 7; // bus disable bit
   localparam int wait_field_lo = 4; // wait field low bit
   localparam int wait_field_hi = 5; // wait field high bit
   localparam int config_field_lo = 0; // 16-bit config field low bit
   localparam int config_field_hi = 1; // 16-bit config field high bit
   // port_g_register pull-up field positions (active low enables)
   localparam int pullup_j_bit = 5; // port j pull-up
   localparam int pullup_e_bit = 6; // port e pull-up
   localparam int pullup_d_bit = 7; // port d pull-up
   // reset values
   localparam logic [1:0] wait_reset = 2'h3; // three instruction cycles
   localparam logic [1:0] config_reset = 2'h0; // first configuration
   localparam logic [2:0] pullup_reset = 3'h7; // all pull-ups disabled
   // 16-bit configuration codes; fourth code reserved
   localparam logic [1:0] cfg_byte_write = 2'h0; // byte write
   localparam logic [1:0] cfg_word_write = 2'h1; // word write
   localparam logic [1:0] cfg_byte_select = 2'h2; // byte select
   // instruction cycle: four clocks
   localparam logic [1:0] clocks_per_cycle_m1 = 2'h3; // divider end count
   // bus cycle phases
   typedef enum logic [2:0] {
      ph_idle,
      ph_addr,
      ph_data,
      ph_wait
   } bus_phase_type;
   // cpu access request carrier
   typedef struct packed {
      logic valid; // access pending
      logic write; // table write
      logic table_op; // table read or write (not a fetch)
      logic [19:0] addr; // byte address
      logic [15:0] wdata; // write data
      logic high_byte; // byte lane for byte writes (1 = high)
      logic word; // full 16-bit write
   } cpu_req_type;
   // external pin carrier
   typedef struct packed {
      logic [15:0] ad_out; // multiplexed address/data out
      logic [15:0] ad_oe; // per-line drive enable
      logic [3:0] upper_addr; // upper address lines
      logic upper_oe; // upper lines drive as bus
      logic chip_enable_n; // chip enable
      logic output_enable_n; // output enable
      logic write_strobe_high_n; // high write strobe
      logic write_strobe_low_n; // low write strobe
      logic high_byte_strobe_n; // high byte strobe
      logic low_byte_strobe_n; // low byte strobe
      logic addr_latch; // address latch enable
      logic byte_addr_bit; // byte address line
   } bus_pins_type;
endpackage

/* cycle_divider.sv */
// instruction-cycle enable divider
`timescale 1ns/100ps
module cycle_divider (
   input wire logic i_clock, // system clock
   input wire logic i_rst_n, // sync reset, active low
   output logic o_cycle_en // one-cycle pulse per instruction cycle
);
   // divider state
   typedef struct packed {
      logic [1:0] count; // clock count within a cycle
   } div_state_type;
   div_state_type state_reg;
   div_state_type state_next;

   // count clocks and wrap at cycle end
   always_comb begin
      state_next = state_reg;
      if (state_reg.count == ext_bus_pkg::clocks_per_cycle_m1) begin
         state_next.count = 2'h0;
      end else begin
         state_next.count = state_reg.count + 2'h1;
      end
   end

   // register with synchronous reset
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_cycle_en = (state_reg.count == ext_bus_pkg::clocks_per_cycle_m1);
endmodule

/* external_memory_bus_ctrl.sv */
// external program memory bus controller with avalon register slave
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module external_memory_bus_ctrl (
   input wire logic i_clock, // 50 MHz clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic [3:0] i_avs_address, // avalon byte address
   input wire logic i_avs_read, // avalon read
   input wire logic i_avs_write, // avalon write
   input wire logic [31:0] i_avs_writedata, // avalon write data
   output logic [31:0] o_avs_readdata, // avalon read data
   output logic o_avs_waitrequest, // avalon wait
   input wire logic i_extended_mode, // 1 = extended program memory mode
   input wire logic i_wait_enable, // wait-state configuration bit
   input wire logic i_addr_width_20, // 1 = 20-bit address, 0 = 16-bit
   input wire logic i_sleep, // device in sleep
   input wire logic i_exec_external, // cpu executing from external memory
   input wire ext_bus_pkg::cpu_req_type i_req, // cpu fetch/table request
   output logic o_req_done, // access finished pulse
   output logic [15:0] o_rdata, // read word
   input wire logic [15:0] i_ad_in, // ad pin input (async)
   output ext_bus_pkg::bus_pins_type o_pins, // bus pin drive
   output logic o_bus_owns_pins, // pins carry bus function
   output logic [2:0] o_pullup_n // pull-ups d,e,j, active low
);
   // full module state
   typedef struct packed {
      // software fields
      logic ext_bus_disable; // programmed bus disable
      logic disable_active; // disable as seen by pins
      logic [1:0] wait_sel; // wait field
      logic [1:0] config_sel; // 16-bit config field
      logic [2:0] pullup_n; // pull-up controls

      // sequencer
      ext_bus_pkg::bus_phase_type phase; // bus cycle phase
      logic [1:0] wait_left; // wait cycles remaining minus one
      logic done; // access done pulse
      logic [15:0] rdata; // captured read data
      logic [31:0] readdata; // avalon read data
      logic ack; // avalon answer cycle

      // pin input synchroniser
      logic [15:0] ad_s1; // pin sync stage 1
      logic [15:0] ad_s2; // pin sync stage 2
      logic [15:0] ad_s3; // pin sync stage 3
      logic [15:0] ad_stable; // agreed pin value

      // pin image
      ext_bus_pkg::bus_pins_type pins; // registered pins
   } ctrl_state_type;
   ctrl_state_type state_reg;
   ctrl_state_type state_next;

   logic cycle_en; // instruction cycle pulse
   logic access; // avalon access pending
   logic in_bus; // pins on bus function

   // instruction cycle divider
   // four clocks per cycle, one pulse each
   cycle_divider u_div (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .o_cycle_en(cycle_en)
   );

   // effective wait from field and enable
   // field value is the cycle count itself
   function automatic logic [1:0] wait_cycles(input logic en,
                                               input logic [1:0] sel);
      wait_cycles = en ? sel : 2'h0;
   endfunction

   // idle pin image: data released, strobes high, latch low
   // also loaded at reset and after every access
   function automatic ext_bus_pkg::bus_pins_type idle_pins();
      ext_bus_pkg::bus_pins_type p;
      // ad drive enables off, lines float
      p = '0;
      p.chip_enable_n = 1'b1;
      p.output_enable_n = 1'b1;
      p.write_strobe_high_n = 1'b1;
      p.write_strobe_low_n = 1'b1;
      p.high_byte_strobe_n = 1'b1;
      p.low_byte_strobe_n = 1'b1;
      idle_pins = p;
   endfunction

   // a read and a write never come together
   assign access = i_avs_read | i_avs_write;

   // pins owned by bus: extended mode, not disabled, or active access
   // an access under way keeps the bus
   // on-chip mode never gives it the pins
   assign in_bus = i_extended_mode &&
                   (!state_reg.disable_active ||
                    state_reg.phase != ext_bus_pkg::ph_idle);

   // next-state logic
   // slave, disable tracker and sequencer own
   // separate fields of the one state copy
   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      state_next.ack = 1'b0;
      // three-stage pin synchroniser; change once stages two and three agree
      // a line toggling each clock never agrees
      // agreed value stands until lines settle
      state_next.ad_s1 = i_ad_in;
      state_next.ad_s2 = state_reg.ad_s1;
      state_next.ad_s3 = state_reg.ad_s2;
      if (state_reg.ad_s2 == state_reg.ad_s3) begin
         state_next.ad_stable = state_reg.ad_s3;
      end

      // avalon slave: one wait cycle then answer
      // the ack cycle blocks a second take
      // a write lands as the request is taken
      if (access && !state_reg.ack) begin
         state_next.ack = 1'b1;
         state_next.readdata = 32'h0;
         case (i_avs_address)
            // control word
            ext_bus_pkg::memory_bus_control_addr: begin
               state_next.readdata[ext_bus_pkg::ext_bus_disable_bit] =
                  state_reg.ext_bus_disable;
               state_next.readdata[ext_bus_pkg::wait_field_hi:
                                   ext_bus_pkg::wait_field_lo] =
                  state_reg.wait_sel;
               state_next.readdata[ext_bus_pkg::config_field_hi:
                                   ext_bus_pkg::config_field_lo] =
                  state_reg.config_sel;
               // writes dropped in on-chip-only mode
               if (i_avs_write && i_extended_mode) begin
                  state_next.ext_bus_disable =
                     i_avs_writedata[ext_bus_pkg::ext_bus_disable_bit];
                  state_next.wait_sel = i_avs_writedata[
                     ext_bus_pkg::wait_field_hi:
                     ext_bus_pkg::wait_field_lo];
                  state_next.config_sel = i_avs_writedata[
                     ext_bus_pkg::config_field_hi:
                     ext_bus_pkg::config_field_lo];
               end
            end

            // pull-ups writable in every mode
            ext_bus_pkg::port_g_register_addr: begin
               state_next.readdata[ext_bus_pkg::pullup_d_bit:
                                   ext_bus_pkg::pullup_j_bit] =
                  state_reg.pullup_n;
               if (i_avs_write) begin
                  state_next.pullup_n = i_avs_writedata[
                     ext_bus_pkg::pullup_d_bit:
                     ext_bus_pkg::pullup_j_bit];
               end
            end

            // read-only view of pin function
            ext_bus_pkg::bus_status_addr: begin
               state_next.readdata[0] = in_bus;
               state_next.readdata[1] = state_reg.disable_active;
               state_next.readdata[2] =
                  state_reg.phase != ext_bus_pkg::ph_idle;
            end

            // any other offset
            default: begin
               state_next.readdata = 32'h0; // unmapped reads zero
            end
         endcase
      end

      // disable reaches pins only from internal execution
      // clearing it returns the bus at once
      if (!state_reg.ext_bus_disable) begin
         state_next.disable_active = 1'b0;
      end else if (!i_exec_external) begin
         state_next.disable_active = 1'b1;
      end

      // bus cycle, stepped per instruction cycle
      // the cpu holds its request until done
      // address and data phases last one instruction cycle each
      if (cycle_en) begin
         case (state_reg.phase)
            ext_bus_pkg::ph_idle: begin
               // on-chip mode and sleep hold requests off
               if (i_req.valid && i_extended_mode && !i_sleep) begin
                  // address phase: latch high, address on ad
                  state_next.phase = ext_bus_pkg::ph_addr;
                  state_next.pins = idle_pins();
                  state_next.pins.chip_enable_n = 1'b0;
                  state_next.pins.addr_latch = 1'b1;
                  state_next.pins.ad_out = i_req.addr[16:1];
                  state_next.pins.ad_oe = 16'hffff;
                  state_next.pins.upper_addr = i_req.addr[19:16];
                  // upper lines stay ports at 16 bits
                  state_next.pins.upper_oe = i_addr_width_20;
                  if (state_reg.config_sel ==
                      ext_bus_pkg::cfg_byte_select) begin
                     state_next.pins.byte_addr_bit = i_req.addr[0];
                  end
               end else begin
                  state_next.pins = idle_pins();
               end
            end

            // data phase setup
            ext_bus_pkg::ph_addr: begin
               state_next.phase = ext_bus_pkg::ph_data;
               state_next.pins.addr_latch = 1'b0;
               if (i_req.write) begin
                  state_next.pins.ad_out = i_req.wdata;
                  // reserved code drives no strobe
                  case (state_reg.config_sel)
                     // lane by its write strobe
                     ext_bus_pkg::cfg_byte_write: begin
                        state_next.pins.write_strobe_high_n =
                           !(i_req.word || i_req.high_byte);
                        state_next.pins.write_strobe_low_n =
                           !(i_req.word || !i_req.high_byte);
                     end
                     // both lanes together
                     ext_bus_pkg::cfg_word_write: begin
                        state_next.pins.write_strobe_high_n = 1'b0;
                        state_next.pins.write_strobe_low_n = 1'b0;
                     end
                     // lanes by the byte strobes
                     ext_bus_pkg::cfg_byte_select: begin
                        state_next.pins.write_strobe_high_n = 1'b0;
                        state_next.pins.write_strobe_low_n = 1'b0;
                        state_next.pins.high_byte_strobe_n =
                           !(i_req.word || i_req.high_byte);
                        state_next.pins.low_byte_strobe_n =
                           !(i_req.word || !i_req.high_byte);
                     end
                     default: begin
                        state_next.pins.write_strobe_high_n = 1'b1;
                        state_next.pins.write_strobe_low_n = 1'b1;
                     end
                  endcase
               end else begin
                  // read: ad released for the memory
                  // both bytes driven together as one word
                  state_next.pins.ad_oe = 16'h0;
                  state_next.pins.output_enable_n = 1'b0;
                  state_next.pins.high_byte_strobe_n = 1'b0;
                  state_next.pins.low_byte_strobe_n = 1'b0;
               end
            end

            // capture, then end or append waits
            ext_bus_pkg::ph_data: begin
               // agreed word of this edge; the register
               // lags a clock and a zero-wait read needs it
               state_next.rdata = state_next.ad_stable;
               if (i_req.table_op &&
                   wait_cycles(i_wait_enable, state_reg.wait_sel) !=
                   2'h0) begin
                  // table operations only
                  state_next.phase = ext_bus_pkg::ph_wait;
                  // owed cycles minus one, as the count runs down to zero
                  state_next.wait_left =
                     wait_cycles(i_wait_enable, state_reg.wait_sel) - 2'h1;
               end else begin
                  state_next.phase = ext_bus_pkg::ph_idle;
                  state_next.done = 1'b1;
                  state_next.pins = idle_pins();
               end
            end

            ext_bus_pkg::ph_wait: begin
               // strobes held through appended wait cycles
               state_next.rdata = state_next.ad_stable;
               // last owed cycle ends the access
               if (state_reg.wait_left == 2'h0) begin
                  state_next.phase = ext_bus_pkg::ph_idle;
                  state_next.done = 1'b1;
                  state_next.pins = idle_pins();
               end else begin
                  state_next.wait_left = state_reg.wait_left - 2'h1;
               end
            end
            default: begin
               state_next.phase = ext_bus_pkg::ph_idle;
            end
         endcase
      end

      // chip enable always released asleep
      // the sequence itself ends normally
      if (i_sleep) begin
         state_next.pins.chip_enable_n = 1'b1;
      end
   end

   // state register, synchronous reset
   // defaults: wait three, pull-ups off, pins idle
   always_ff @(posedge i_clock) begin
      if (!i_rst_n) begin
         // every field cleared, then defaults
         state_reg <= '0;
         state_reg.wait_sel <= ext_bus_pkg::wait_reset;
         state_reg.config_sel <= ext_bus_pkg::config_reset;
         state_reg.pullup_n <= ext_bus_pkg::pullup_reset;
         state_reg.pins <= idle_pins();
      end else begin
         state_reg <= state_next;
      end
   end

   // avalon answer: waitrequest low in the ack cycle
   // data outputs and done are flip-flops, waitrequest not
   assign o_avs_waitrequest = access && !state_reg.ack;
   assign o_avs_readdata = state_reg.readdata;
   assign o_req_done = state_reg.done;
   assign o_rdata = state_reg.rdata;

   // bus pins take priority over every other pin function
   assign o_bus_owns_pins = in_bus;
   assign o_pins = state_reg.pins;
   assign o_pullup_n = state_reg.pullup_n;
endmodule

/* ext_mem_model.sv */
// behavioural external parallel memory on the multiplexed bus
`timescale 1ns/100ps
module ext_mem_model (
   input wire logic i_clock, // clock
   input wire ext_bus_pkg::bus_pins_type i_pins, // pin drive
   output logic [15:0] o_ad // data back to ad pins
);
   logic [15:0] mem [0:255]; // storage by word address
   logic [15:0] addr_reg = 16'h0; // latched word address
   logic [15:0] junk_reg = 16'h5a5a; // pattern of a released bus
   logic wr; // some write strobe low while selected
   logic hi_en; // high lane written
   logic lo_en; // low lane written
   logic bsel; // byte strobes pick the lanes
   assign wr = !i_pins.chip_enable_n && !(i_pins.write_strobe_high_n
      && i_pins.write_strobe_low_n);
   // byte strobes pick the lanes when low, else the write strobes do
   assign bsel = !(i_pins.high_byte_strobe_n && i_pins.low_byte_strobe_n);
   assign hi_en = wr && (bsel ? !i_pins.high_byte_strobe_n
      : !i_pins.write_strobe_high_n);
   assign lo_en = wr && (bsel ? !i_pins.low_byte_strobe_n
      : !i_pins.write_strobe_low_n);
   // drive only while selected and output enabled, else junk
   assign o_ad = (!i_pins.chip_enable_n && !i_pins.output_enable_n) ?
      mem[addr_reg[7:0]] : junk_reg;
   // address latch and lane writes
   always @(posedge i_clock) begin
      junk_reg <= ~junk_reg;
      if (i_pins.addr_latch) addr_reg <= i_pins.ad_out;
      if (hi_en) mem[addr_reg[7:0]][15:8] <= i_pins.ad_out[15:8];
      if (lo_en) mem[addr_reg[7:0]][7:0] <= i_pins.ad_out[7:0];
   end
endmodule

/* external_memory_bus_ctrl_monitor.sv */
// checker of pin states and pull-ups at the block's ports
`timescale 1ns/100ps
module ext_bus_monitor (
   input wire logic i_clock, // clock
   input wire logic i_rst_n, // sync reset, active low
   input wire logic i_sleep, // sleep
   input wire logic i_extended_mode, // mode
   input wire logic i_addr_width_20, // address width
   input wire ext_bus_pkg::cpu_req_type i_req, // cpu request
   input wire ext_bus_pkg::bus_pins_type o_pins, // pins
   input wire logic o_bus_owns_pins, // bus owns pins
   input wire logic [2:0] o_pullup_n // pull-ups
);
   logic idle; // strobes, latch, byte address and ad drive in the inactive state
   assign idle = o_pins.chip_enable_n && o_pins.output_enable_n &&
      o_pins.write_strobe_high_n && o_pins.write_strobe_low_n &&
      o_pins.high_byte_strobe_n && o_pins.low_byte_strobe_n &&
      !o_pins.addr_latch && !o_pins.byte_addr_bit && o_pins.ad_oe == 16'h0;
   default clocking @(posedge i_clock); endclocking
   AST_PULLUP_RST: assert property (disable iff (1'b0)
      !i_rst_n [*2] |-> o_pullup_n == 3'h7) else $error("pull-up on in reset");
   AST_IDLE_RST: assert property (disable iff (1'b0)
      !i_rst_n [*2] |-> idle) else $error("pins not idle in reset");
   AST_CE_IDLE: assert property (disable iff (!i_rst_n)
      o_pins.chip_enable_n |-> idle) else $error("strobe active while idle");
   AST_SLEEP_CE: assert property (disable iff (!i_rst_n)
      i_sleep [*2] |-> o_pins.chip_enable_n) else $error("chip on in sleep");
   AST_ALE_CE: assert property (disable iff (!i_rst_n)
      o_pins.addr_latch |-> !o_pins.chip_enable_n) else $error("latch no ce");
   AST_ALE_ADDR: assert property (disable iff (!i_rst_n)
      o_pins.addr_latch |-> o_pins.ad_out == i_req.addr[16:1]
      && &o_pins.ad_oe) else $error("address not on ad lines");
   AST_ALE_OE: assert property (disable iff (!i_rst_n)
      $rose(o_pins.addr_latch) && !i_req.write |-> ##[1:8]
      !o_pins.output_enable_n) else $error("no output enable");
   AST_ONCHIP: assert property (disable iff (!i_rst_n)
      !i_extended_mode [*2] |-> !o_bus_owns_pins && o_pins.chip_enable_n)
      else $error("bus active in on-chip mode");
   AST_OWNS: assert property (disable iff (!i_rst_n)
      !o_pins.chip_enable_n |-> o_bus_owns_pins) else $error("access no bus");
   AST_UPPER: assert property (disable iff (!i_rst_n)
      !i_addr_width_20 [*2] |-> !o_pins.upper_oe) else $error("upper driven");
endmodule
bind external_memory_bus_ctrl ext_bus_monitor mon (.i_clock(i_clock),
   .i_rst_n(i_rst_n), .i_sleep(i_sleep), .i_extended_mode(i_extended_mode),
   .i_addr_width_20(i_addr_width_20), .i_req(i_req), .o_pins(o_pins),
   .o_bus_owns_pins(o_bus_owns_pins), .o_pullup_n(o_pullup_n));

/* external_memory_bus_ctrl_bench.sv */
// self-checking bench of the external memory bus controller
`timescale 1ns/100ps
module external_memory_bus_ctrl_bench;
   logic i_clock = 1'b0; // clock
   logic i_rst_n = 1'b0; // reset
   logic [3:0] av_addr = 4'h0; // avalon address
   logic av_rd = 1'b0; // avalon read
   logic av_wr = 1'b0; // avalon write
   logic [31:0] av_wd = 32'h0; // avalon write data
   logic [31:0] av_rdata; // avalon read data
   logic av_wait; // avalon waitrequest
   logic ext_mode = 1'b0; // extended mode
   logic wait_en = 1'b1; // wait configuration
   logic width20 = 1'b0; // address width
   logic sleep = 1'b1; // sleep
   logic exec_ext = 1'b0; // executing externally
   ext_bus_pkg::cpu_req_type req = '0; // cpu request
   logic done; // access done
   logic [15:0] rdata; // read word
   logic [15:0] ad_in; // ad pins back
   ext_bus_pkg::bus_pins_type pins; // pin drive
   logic owns; // bus owns pins
   logic [2:0] pull_n; // pull-ups
   logic [31:0] rq[$]; // expected register reads
   logic [15:0] dq[$]; // expected bus reads
   logic [15:0] shadow_a; // expected word at the test address
   logic [31:0] seed = 32'h7334; // random state
   logic ba_last = 1'b0; // byte address at last latch
   logic upper_seen = 1'b0; // upper lines driven
   int fail_count = 0; // mismatches
   int compares = 0; // comparisons
   int cyc = 0; // cycle count
   int span = 0; // cycles since address latch
   int lat; // latch to done
   int lat0; // latency without waits
   int waited; // cycles a request waited
   localparam logic [19:0] a = 20'h00446; // test address
   always #10 i_clock = ~i_clock;
   external_memory_bus_ctrl uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
      .i_avs_writedata(av_wd), .o_avs_readdata(av_rdata),
      .o_avs_waitrequest(av_wait), .i_extended_mode(ext_mode),
      .i_wait_enable(wait_en), .i_addr_width_20(width20), .i_sleep(sleep),
      .i_exec_external(exec_ext), .i_req(req), .o_req_done(done),
      .o_rdata(rdata), .i_ad_in(ad_in), .o_pins(pins),
      .o_bus_owns_pins(owns), .o_pullup_n(pull_n));
   ext_mem_model mem (.i_clock(i_clock), .i_pins(pins), .o_ad(ad_in));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // avalon transfer held until waitrequest is seen low
   task automatic av_xfer(input logic w, input logic [3:0] ad,
      input logic [31:0] d);
      av_addr <= ad;
      av_wd <= d;
      av_wr <= w;
      av_rd <= !w;
      do @(posedge i_clock); while (av_wait !== 1'b0);
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic av_read(input logic [3:0] ad, input logic [31:0] exp);
      rq.push_back(exp);
      av_xfer(1'b0, ad, 32'h0);
   endtask
   // cpu request held until done; lat counts from the address latch
   task automatic cpu(input logic w, input logic t, input logic [19:0] ad,
      input logic [15:0] d, input logic wd, input logic hi);
      if (!w) dq.push_back(shadow_a);
      req <= '{1'b1, w, t, ad, d, hi, wd};
      waited = 0;
      do begin
         @(posedge i_clock);
         waited++;
      end while (done !== 1'b1);
      lat = span;
      req.valid <= 1'b0;
      @(posedge i_clock);
   endtask
   // watcher: oldest note against each answer
   always @(posedge i_clock) begin
      cyc++;
      span <= pins.addr_latch ? 0 : span + 1;
      if (pins.addr_latch) ba_last <= pins.byte_addr_bit;
      if (pins.upper_oe) upper_seen <= 1'b1;
      if (av_rd && !av_wait) check(av_rdata, rq.pop_front());
      if (done && !req.write) check({16'h0, rdata}, {16'h0, dq.pop_front()});
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      repeat (8) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      check({29'h0, pull_n}, 32'h7);
      av_read(4'h0, 32'h30);
      av_read(4'h4, 32'he0);
      av_read(4'hc, 32'h0);
      av_xfer(1'b1, 4'h0, 32'h81);
      av_read(4'h0, 32'h30);
      seed = lfsr(seed);
      av_xfer(1'b1, 4'h4, seed);
      av_read(4'h4, seed & 32'he0);
      check({29'h0, pull_n}, {29'h0, seed[7:5]});
      // a request waits through on-chip mode and sleep
      fork
         begin
            repeat (40) @(posedge i_clock);
            ext_mode <= 1'b1;
            repeat (40) @(posedge i_clock);
            sleep <= 1'b0;
         end
      join_none
      cpu(1'b1, 1'b1, 20'h00200, seed[15:0], 1'b0, 1'b1);
      check(32'(waited > 80), 32'h1);
      av_xfer(1'b1, 4'h0, 32'h01);
      seed = lfsr(seed);
      shadow_a = seed[15:0];
      cpu(1'b1, 1'b1, a, shadow_a, 1'b1, 1'b0);
      av_xfer(1'b1, 4'h0, 32'h00);
      seed = lfsr(seed);
      shadow_a[15:8] = seed[15:8];
      cpu(1'b1, 1'b1, a, seed[15:0], 1'b0, 1'b1);
      cpu(1'b0, 1'b1, a, 16'h0, 1'b1, 1'b0);
      for (int w = 0; w < 4; w++) begin
         av_xfer(1'b1, 4'h0, 32'(w * 16 + 1));
         cpu(1'b0, 1'b1, a, 16'h0, 1'b1, 1'b0);
         if (w == 0) lat0 = lat;
         check(32'(lat - lat0), 32'(4 * w));
      end
      wait_en <= 1'b0;
      cpu(1'b0, 1'b1, a, 16'h0, 1'b1, 1'b0);
      check(32'(lat), 32'(lat0));
      wait_en <= 1'b1;
      av_xfer(1'b1, 4'h0, 32'h02);
      seed = lfsr(seed);
      shadow_a[7:0] = seed[7:0];
      cpu(1'b1, 1'b1, a, seed[15:0], 1'b0, 1'b0);
      width20 <= 1'b1;
      cpu(1'b0, 1'b0, a | 20'h1, 16'h0, 1'b1, 1'b0);
      check({31'h0, ba_last}, 32'h1);
      check({31'h0, upper_seen}, 32'h1);
      width20 <= 1'b0;
      av_xfer(1'b1, 4'h0, 32'h81);
      check({31'h0, owns}, 32'h0);
      av_xfer(1'b1, 4'h0, 32'h01);
      check({31'h0, owns}, 32'h1);
      exec_ext <= 1'b1;
      av_xfer(1'b1, 4'h0, 32'h81);
      check({31'h0, owns}, 32'h1);
      exec_ext <= 1'b0;
      repeat (2) @(posedge i_clock);
      check({31'h0, owns}, 32'h0);
      av_read(4'h8, 32'h2);
      cpu(1'b0, 1'b0, a, 16'h0, 1'b1, 1'b0);
      check({31'h0, ba_last}, 32'h0);
      final_report();
   end
endmodule
